/* File: hdl/vsync_pkg.sv */
// Package: constants and carrier types for the vertical sync detector
package vsync_pkg;

  localparam int INTEG_WIDTH = 16;
  localparam int PRESCALE_WIDTH = 16;
  localparam int PULSE_CYCLES = 8;
  localparam logic [3:0] PULSE_COUNT_LAST = 4'h7;
  localparam logic [INTEG_WIDTH-1:0] INTEG_RESET = 16'h0000;
  localparam logic [INTEG_WIDTH-1:0] INTEG_MAX = 16'hFFFF;
  localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 16'h0000;
  // Idle level of the active-low sync pin, so reset leaves no false edge
  localparam logic [2:0] SYNC_PIPE_RESET = 3'h7;

  // Rate settings standing in for the external rate resistor
  typedef struct packed {
    logic [INTEG_WIDTH-1:0] charge_step;
    logic [INTEG_WIDTH-1:0] decay_step;
    logic [INTEG_WIDTH-1:0] serration_threshold;
    logic [INTEG_WIDTH-1:0] default_threshold;
    logic [PRESCALE_WIDTH-1:0] osc_period;
  } rate_cfg_s;

  // Outputs towards downstream video timing logic
  typedef struct packed {
    logic csync;
    logic vsync_n;
    logic field_odd;
  } timing_out_s;

endpackage

/* File: hdl/sync_input_filter.sv */
// Three-stage pin synchroniser with agreement on the last two stages
module sync_input_filter (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out
);

  logic [2:0] pipe_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pipe_reg <= vsync_pkg::SYNC_PIPE_RESET;
    end else begin
      pipe_reg <= {pipe_reg[1:0], pin_in};
    end
  end

  // Stage 0 feeds only stage 1; a change counts when stages 1 and 2 agree
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level_out <= vsync_pkg::SYNC_PIPE_RESET[2];
    end else if (pipe_reg[1] == pipe_reg[2]) begin
      level_out <= pipe_reg[2];
    end
  end

endmodule

/* File: hdl/video_vertical_sync_detector.sv */
// Vertical sync detector: integrator, vertical latch, oscillator, field flag
// Summary of operation
// - Buffer separated sync out as composite sync
// - Integrator charges while sync pulse is active
// - Charge rate is a resistor-derived setting
// - Normal lines stay below serration threshold
// - Capture lower comparator on serration falling edge
// - Captured bit sets latch through OR
// - Latch enables oscillator, clocks field flip-flop
// - Clear latch after eight oscillator cycles
// - Vertical output is inverted latch
// - Oscillator period is resistor-derived setting
// - No pulse if threshold not reached
// - Later serration edge may retrigger latch
// - Default threshold sets latch without serrations
// - Pulse end recaptures comparator, retriggers
// - Field output low even, high odd
module video_vertical_sync_detector (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic csync_n_in,
  input wire vsync_pkg::rate_cfg_s rate_set_resistor_in,
  output vsync_pkg::timing_out_s timing_out,
  output logic [vsync_pkg::INTEG_WIDTH-1:0] integ_level_out
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PULSE = 2'b10
  } vstate_e;

  logic csync_n_lvl;
  logic sync_act;
  logic sync_act_reg;
  logic serr_fall;
  logic sync_rise;
  logic latch_set;
  logic csync_reg;
  logic vsync_n_reg;
  logic field_odd_reg;
  logic [vsync_pkg::INTEG_WIDTH-1:0] integ_reg;
  logic [vsync_pkg::INTEG_WIDTH-1:0] integ_next;
  logic above_serr;
  logic above_dflt;
  logic capture_reg;
  logic set_req;
  vstate_e state_reg;
  logic [vsync_pkg::PRESCALE_WIDTH-1:0] prescale_reg;
  logic osc_tick;
  logic [3:0] cycle_reg;
  logic pulse_end;
  logic field_q_reg;
  logic short_gap;
  logic [vsync_pkg::INTEG_WIDTH-1:0] gap_reg;

  function automatic logic [vsync_pkg::INTEG_WIDTH-1:0] sat_add(
    input logic [vsync_pkg::INTEG_WIDTH-1:0] a,
    input logic [vsync_pkg::INTEG_WIDTH-1:0] b
  );
    logic [vsync_pkg::INTEG_WIDTH:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[vsync_pkg::INTEG_WIDTH] ? vsync_pkg::INTEG_MAX
                                     : s[vsync_pkg::INTEG_WIDTH-1:0];
  endfunction

  sync_input_filter u_csync_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(csync_n_in),
    .level_out(csync_n_lvl)
  );

  // Sync is inverted internally so pulses are positive going
  assign sync_act = ~csync_n_lvl;
  // Serration edge: internal sync going inactive starts the serration, so
  // the comparator is read at the peak of the broad pulse, before decay
  assign serr_fall = ~sync_act & sync_act_reg;
  // Start of any sync pulse, used to time the gap before it
  assign sync_rise = sync_act & ~sync_act_reg;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_act_reg <= 1'b0;
    end else begin
      sync_act_reg <= sync_act;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      csync_reg <= 1'b1;
    end else begin
      csync_reg <= csync_n_lvl;
    end
  end

  // One driver for the whole output struct; each field is a flip-flop
  assign timing_out = '{
    csync: csync_reg,
    vsync_n: vsync_n_reg,
    field_odd: field_odd_reg
  };

  // Saturating counter; decay keeps short horizontal sync from building up
  always_comb begin
    if (sync_act) begin
      integ_next = sat_add(integ_reg, rate_set_resistor_in.charge_step);
    end else if (integ_reg > rate_set_resistor_in.decay_step) begin
      integ_next = integ_reg - rate_set_resistor_in.decay_step;
    end else begin
      integ_next = vsync_pkg::INTEG_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      integ_reg <= vsync_pkg::INTEG_RESET;
    end else begin
      integ_reg <= integ_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      integ_level_out <= vsync_pkg::INTEG_RESET;
    end else begin
      integ_level_out <= integ_reg;
    end
  end

  assign above_serr = integ_reg >= rate_set_resistor_in.serration_threshold;
  assign above_dflt = integ_reg >= rate_set_resistor_in.default_threshold;

  // D flip-flop clocked by serration edges and by the end of a pulse
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      capture_reg <= 1'b0;
    end else if (serr_fall || pulse_end) begin
      capture_reg <= above_serr;
    end else if (state_reg == ST_PULSE) begin
      capture_reg <= 1'b0;
    end
  end

  assign set_req = capture_reg | above_dflt;
  // Setting edge of the latch: idle and asked to set
  assign latch_set = (state_reg == ST_IDLE) && set_req;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (set_req) begin
            state_reg <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (pulse_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Oscillator runs only while the latch is set
  assign osc_tick = (state_reg == ST_PULSE)
    && (prescale_reg >= rate_set_resistor_in.osc_period);
  assign pulse_end = osc_tick && (cycle_reg == vsync_pkg::PULSE_COUNT_LAST);

  always_ff @(posedge clk_in) begin
    if (reset_in || state_reg != ST_PULSE || osc_tick) begin
      prescale_reg <= vsync_pkg::PRESCALE_RESET;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || state_reg != ST_PULSE) begin
      cycle_reg <= 4'h0;
    end else if (osc_tick) begin
      cycle_reg <= cycle_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vsync_n_reg <= 1'b1;
    end else begin
      vsync_n_reg <= ~((state_reg == ST_PULSE) && !pulse_end)
        & ~latch_set;
    end
  end

  // Gap detector: long gap between syncs clears the toggle, short ones flip it
  always_ff @(posedge clk_in) begin
    if (reset_in || sync_act) begin
      gap_reg <= vsync_pkg::INTEG_RESET;
    end else begin
      gap_reg <= sat_add(gap_reg, rate_set_resistor_in.charge_step);
    end
  end

  // A half-line gap stays short of the threshold, a full line does not
  assign short_gap = gap_reg < rate_set_resistor_in.serration_threshold;

  // Clocked by each sync start; a field that ends on a half line leaves
  // the toggle in the opposite polarity at the latch's setting edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      field_q_reg <= 1'b0;
    end else if (sync_rise) begin
      field_q_reg <= short_gap ? ~field_q_reg : 1'b0;
    end
  end

  // Field flag sampled on the latch's setting edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      field_odd_reg <= 1'b0;
    end else if (latch_set) begin
      field_odd_reg <= field_q_reg;
    end
  end

endmodule

/* File: testbench/vsync_detector_properties.sv */
// Port checker for the vertical sync detector
module vsync_detector_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic csync_n_in,
  input wire vsync_pkg::rate_cfg_s rate_set_resistor_in,
  input wire vsync_pkg::timing_out_s timing_out,
  input wire logic [vsync_pkg::INTEG_WIDTH-1:0] integ_level_out
);
  wire vs = timing_out.vsync_n;
  wire [15:0] iv = integ_level_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  csync_low_a: assert property (!csync_n_in [*7] |-> !timing_out.csync)
    else $error("csync high");
  csync_high_a: assert property (csync_n_in [*7] |-> timing_out.csync)
    else $error("csync low");
  charge_up_a: assert property (!csync_n_in [*8] |-> iv >= $past(iv))
    else $error("no charge");
  decay_down_a: assert property (csync_n_in [*8] |-> iv <= $past(iv))
    else $error("no decay");
  thresh_set_a: assert property ($fell(vs) |->
    iv >= rate_set_resistor_in.serration_threshold) else $error("early");
  // Bounds fit the bench's osc_period of 9, an 80-cycle pulse
  pulse_width_a: assert property ($fell(vs) |=> !vs [*8] ##[71:73] vs)
    else $error("pulse width");
  field_set_a: assert property ($changed(timing_out.field_odd) |->
    ##[0:2] $fell(vs)) else $error("field moved");
  default_set_a: assert property (vs &&
    iv >= rate_set_resistor_in.default_threshold |-> ##[0:3] !vs)
    else $error("no default");
  cover property ($fell(vs));
  cover property (iv >= rate_set_resistor_in.default_threshold);
  cover property ($changed(timing_out.field_odd));
endmodule

bind video_vertical_sync_detector vsync_detector_properties u_props (
  .clk_in(clk_in), .reset_in(reset_in), .csync_n_in(csync_n_in),
  .rate_set_resistor_in(rate_set_resistor_in), .timing_out(timing_out),
  .integ_level_out(integ_level_out));

/* File: testbench/video_source_model.sv */
// Composite sync source model: normal lines and vertical half lines
module video_source_model (
  input wire logic clk_in,
  output logic csync_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial csync_n_out = 1'b1;
  // Entered at a falling edge; sync tip for lo cycles, then hi high
  task automatic pulse(input int lo, input int hi);
    csync_n_out = 1'b0;
    repeat (lo) @(negedge clk_in);
    csync_n_out = 1'b1;
    repeat (hi) @(negedge clk_in);
  endtask
  task automatic line();
    pulse(4, 60);
  endtask
  // Tip holds 90 percent of the half line
  task automatic vhalf();
    pulse(36, 4);
  endtask
endmodule

/* File: testbench/video_vertical_sync_detector_tb_top.sv */
// Self-checking bench for the vertical sync detector
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); n_mismatch++; end end
module video_vertical_sync_detector_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic csync_n;
  vsync_pkg::rate_cfg_s cfg = '0;
  vsync_pkg::timing_out_s tout;
  logic [15:0] integ;
  logic vs_prev = 1'b1;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_falls = 0;
  int cycles = 0;
  initial forever #10 clk_in = ~clk_in;
  video_source_model u_src (.clk_in(clk_in), .csync_n_out(csync_n));
  video_vertical_sync_detector u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .csync_n_in(csync_n), .rate_set_resistor_in(cfg), .timing_out(tout),
    .integ_level_out(integ));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Outputs are looked at on the falling edge, where they have settled
  always @(negedge clk_in) begin
    cycles++;
    if (vs_prev && !tout.vsync_n) n_falls++;
    vs_prev = tout.vsync_n;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Config only changes under reset, as it is static in use
  task automatic restart(input logic [15:0] chg, input logic [15:0] dec);
    @(negedge clk_in);
    reset_in = 1'b1;
    cfg = '{chg, dec, 16'h0100, 16'h2000, 16'h0009};
    repeat (12) @(negedge clk_in);
    reset_in = 1'b0;
    n_falls = 0;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic sc_serration();
    restart(16'h0010, 16'h0020);
    repeat (2) u_src.line();
    u_src.vhalf();
    `CHK("vsync lines", 1'b1, tout.vsync_n)
    u_src.vhalf();
    `CHK("vsync edge", 1'b0, tout.vsync_n)
    repeat (4) u_src.line();
    `CHK("falls", 1, n_falls)
    `CHK("vsync end", 1'b1, tout.vsync_n)
  endtask
  task automatic sc_slow_charge();
    restart(16'h0004, 16'h0020);
    repeat (2) u_src.line();
    repeat (2) u_src.vhalf();
    repeat (4) u_src.line();
    `CHK("slow falls", 0, n_falls)
  endtask
  task automatic sc_default();
    restart(16'h0010, 16'h0100);
    fork
      u_src.pulse(540, 100);
      begin
        repeat (500) @(negedge clk_in);
        `CHK("vsync wait", 1'b1, tout.vsync_n)
        repeat (40) @(negedge clk_in);
        `CHK("vsync dflt", 1'b0, tout.vsync_n)
      end
    join
    `CHK("dflt falls", 1, n_falls)
    `CHK("dflt end", 1'b1, tout.vsync_n)
  endtask
  // Three broad half lines outlast one output pulse, which then restarts
  task automatic sc_retrigger();
    restart(16'h0010, 16'h0020);
    u_src.line();
    repeat (3) u_src.vhalf();
    u_src.line();
    `CHK("vsync again", 1'b0, tout.vsync_n)
    repeat (3) u_src.line();
    `CHK("again falls", 2, n_falls)
    `CHK("again end", 1'b1, tout.vsync_n)
  endtask
  // Odd field: a pulse spaced 12 cycles, well under a half line, just before the vertical interval
  task automatic sc_field();
    restart(16'h0010, 16'h0020);
    u_src.line();
    u_src.pulse(4, 8);
    repeat (2) u_src.vhalf();
    `CHK("odd field", 1'b1, tout.field_odd)
    repeat (4) u_src.line();
    `CHK("odd holds", 1'b1, tout.field_odd)
    repeat (2) u_src.vhalf();
    `CHK("even field", 1'b0, tout.field_odd)
    repeat (4) u_src.line();
    `CHK("field falls", 2, n_falls)
  endtask
  initial begin
    sc_serration();
    sc_slow_charge();
    sc_default();
    sc_retrigger();
    sc_field();
    report_and_stop();
  end
endmodule
